// ==== line_config_defines.svh ====
// register map, field positions, reset values and timing counts of the line block
`ifndef LINE_CONFIG_DEFINES_SVH
`define LINE_CONFIG_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL 6'h00
`define OFS_HALF 6'h04
`define OFS_TMO  6'h08
`define OFS_FUNC 6'h0c
`define OFS_OUT  6'h10
`define OFS_DIR  6'h14
`define OFS_IN   6'h18
`define OFS_CMD  6'h1c
`define OFS_STAT 6'h20
`define OFS_MASK 6'h24
`define OFS_LIVE 6'h28

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_SER  0
`define CTRL_STB  1
`define CTRL_WAIT 2
`define CTRL_RUN  3
`define CTRL_WID  4
`define CMD_STB   0
`define CMD_WAIT  1
`define ST_STB    0
`define ST_DONE   1
`define ST_TMO    2
`define ST_REJ    3
`define LIVE_STB  0
`define LIVE_WAIT 1
`define LIVE_SCLK 2
`define LN_SCLK   0
`define LN_SEL    1
`define LN_MOSI   2
`define LN_MISO   3
`define LN_STB    4
`define LN_CMP    5

// ****************************************************************
// reset values, limits and timing
// ****************************************************************
`define HALF_RST     16'h0002
`define HALF_MIN     16'h0002
`define TMO_RST      32'h0000_ffff
`define TMO_MAX      32'hffff_fffe
`define CLK_NS       20
`define STB_SHORT_NS 100
`define STB_MED_NS   200
`define STB_LONG_NS  400
`define NS_TO_CYC(t) (((t) + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== line_config_pkg.sv ====
// types shared by the line block modules
package line_config_pkg;

  typedef enum logic [1:0] {STB_IDLE = 2'b00, STB_PULSE = 2'b01} strobe_state_t;
  typedef enum logic [1:0] {WAIT_IDLE = 2'b00, WAIT_RUN = 2'b01} wait_state_t;

  typedef enum logic [2:0] {
    FN_UNUSED       = 3'h0,
    FN_TWO_WAY      = 3'h1,
    FN_FIXED_HIGH   = 3'h2,
    FN_FIXED_LOW    = 3'h3,
    FN_RECEIVE_ONLY = 3'h4
  } line_fn_t;

  typedef struct packed {
    logic        level;
    logic        active;
    logic [15:0] cnt;
  } sclk_state_t;

  typedef struct packed {
    logic          ser_en;
    logic          stb_en;
    logic          wait_en;
    logic          ser_run;
    logic [1:0]    width;
    logic [15:0]   half;
    logic [31:0]   tmo;
    logic [26:0]   func;
    logic [8:0]    dout;
    logic [8:0]    ddir;
    logic [3:0]    status;
    logic [3:0]    mask;
    strobe_state_t sst;
    logic [4:0]    scnt;
    wait_state_t   wst;
    logic [31:0]   wcnt;
    logic [8:0]    sync1;
    logic [8:0]    sync2;
    logic [8:0]    pin_out;
    logic [8:0]    pin_oe;
    logic          irq;
    logic          resp;
    logic [31:0]   rdata;
  } line_state_t;

endpackage

// ==== serial_clock_gen.sv ====
// symmetric serial clock generator with a programmable half period
`timescale 1ns/1ps

module serial_clock_gen (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [15:0] half_count,
  output logic             sclk
);

  line_config_pkg::sclk_state_t s;
  line_config_pkg::sclk_state_t n;

  always_comb begin
    n = s;
    if (!run) begin
      n = '0;
    end else if (!s.active) begin
      n.active = 1'b1;
      n.level  = 1'b1;
      n.cnt    = 16'h0001;
    end else if (s.cnt >= half_count) begin
      // >= so a shrunk half period never runs the count away
      n.level = ~s.level;
      n.cnt   = 16'h0001;
    end else begin
      n.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sclk = s.level;

  half_period_a: assert property (@(posedge clk_sys) disable iff (rst)
    (s.active && $past(s.active) && $stable(half_count) && s.level != $past(s.level))
    |-> $past(s.cnt) == half_count)
    else $error("serial clock phase length differs from half period");

endmodule // serial_clock_gen

// ==== module_bus_line_config.sv ====
// backplane line configuration block: serial clock, strobe, completion wait, general lines
// Notes on behaviour
// - serial enable reserves clock, select, MOSI, MISO
// - half period count accepted from 2 upward
// - serial clock high and low equally long
// - strobe line reserved and usable only when enabled
// - strobe width short, medium or long
// - completion wait times out with error flag
// - timeout count accepted up to fffffffe
// - two-way line: input at start, may drive
// - fixed high line drives high, writes ignored
// - fixed low line drives low, writes ignored
// - receive-only or unused line never drives
// - reserved lines refuse general line functions
// - unconfigured free line behaves as unused
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "line_config_defines.svh"

module module_bus_line_config (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic [8:0]  line_in,
  output logic      [8:0]  line_out,
  output logic      [8:0]  line_oe
);

  // ****************************************************************
  // state and helpers
  // ****************************************************************
  line_config_pkg::line_state_t s;
  line_config_pkg::line_state_t n;
  logic        sclk;
  logic        acc;
  logic        wr_take;
  logic        cmd_stb;
  logic        cmd_wait;
  logic [5:0]  addr;
  logic [31:0] rd;
  logic [31:0] wf;
  logic [3:0]  set;
  logic [3:0]  clr;
  logic [8:0]  res;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction
  function automatic logic [4:0] strobe_cycles(input logic [1:0] sel);
    logic [4:0] c;
    case (sel)
      2'h0:    c = 5'(`NS_TO_CYC(`STB_SHORT_NS));
      2'h1:    c = 5'(`NS_TO_CYC(`STB_MED_NS));
      default: c = 5'(`NS_TO_CYC(`STB_LONG_NS));
    endcase
    return c;
  endfunction
  function automatic line_config_pkg::line_fn_t fn_of(input logic [26:0] f, input int i);
    logic [2:0] c;
    c = f[i*3 +: 3];
    // codes past the last function fall back to unused
    if (c > 3'h4) begin
      return line_config_pkg::FN_UNUSED;
    end
    return line_config_pkg::line_fn_t'(c);
  endfunction
  function automatic logic [8:0] reserved(input logic ser, input logic stb, input logic wt);
    logic [8:0] m;
    m            = 9'h000;
    m[`LN_SCLK]  = ser;
    m[`LN_SEL]   = ser;
    m[`LN_MOSI]  = ser;
    m[`LN_MISO]  = ser;
    m[`LN_STB]   = stb;
    m[`LN_CMP]   = wt;
    return m;
  endfunction
  function automatic logic func_ok(input logic [26:0] f, input logic [8:0] m);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 9; i++) begin
      if (f[i*3 +: 3] > 3'h4 || (m[i] && f[i*3 +: 3] != 3'h0)) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // ****************************************************************
  // serial clock
  // ****************************************************************
  serial_clock_gen u_sclk (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .run        (s.ser_en & s.ser_run),
    .half_count (s.half),
    .sclk       (sclk)
  );

  // ****************************************************************
  // bus slave
  // ****************************************************************
  assign addr     = {avs_address, 2'b00};
  assign acc      = avs_read | avs_write;
  assign wr_take  = s.resp & avs_write;
  assign wf       = merge_bytes(rd, avs_writedata, avs_byteenable);
  assign cmd_stb  = wr_take && addr == `OFS_CMD && wf[`CMD_STB];
  assign cmd_wait = wr_take && addr == `OFS_CMD && wf[`CMD_WAIT];

  always_comb begin
    rd = 32'h0;
    case (addr)
      `OFS_CTRL: begin
        rd[`CTRL_SER]      = s.ser_en;
        rd[`CTRL_STB]      = s.stb_en;
        rd[`CTRL_WAIT]     = s.wait_en;
        rd[`CTRL_RUN]      = s.ser_run;
        rd[`CTRL_WID +: 2] = s.width;
      end
      `OFS_HALF: rd[15:0] = s.half;
      `OFS_TMO:  rd       = s.tmo;
      `OFS_FUNC: rd[26:0] = s.func;
      `OFS_OUT:  rd[8:0]  = s.dout;
      `OFS_DIR:  rd[8:0]  = s.ddir;
      `OFS_IN:   rd[8:0]  = s.sync2;
      `OFS_STAT: rd[3:0]  = s.status;
      `OFS_MASK: rd[3:0]  = s.mask;
      `OFS_LIVE: begin
        rd[`LIVE_STB]  = s.sst == line_config_pkg::STB_PULSE;
        rd[`LIVE_WAIT] = s.wst == line_config_pkg::WAIT_RUN;
        rd[`LIVE_SCLK] = sclk;
      end
      default:   rd = 32'h0;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n       = s;
    set     = 4'h0;
    clr     = 4'h0;
    n.sync1 = line_in;
    n.sync2 = s.sync1;
    n.resp  = acc & ~s.resp;
    if (acc && !s.resp) begin
      n.rdata = rd;
    end
    // only bits already reported are cleared, so later events survive
    if (s.resp && avs_read && addr == `OFS_STAT) begin
      clr = s.rdata[3:0];
    end
    if (wr_take) begin
      case (addr)
        `OFS_CTRL: begin
          n.ser_en  = wf[`CTRL_SER];
          n.stb_en  = wf[`CTRL_STB];
          n.wait_en = wf[`CTRL_WAIT];
          n.ser_run = wf[`CTRL_RUN];
          if (wf[`CTRL_WID +: 2] == 2'h3) begin
            set[`ST_REJ] = 1'b1;
          end else begin
            n.width = wf[`CTRL_WID +: 2];
          end
        end
        `OFS_HALF: begin
          if (wf[15:0] >= `HALF_MIN) begin
            n.half = wf[15:0];
          end else begin
            set[`ST_REJ] = 1'b1;
          end
        end
        `OFS_TMO: begin
          if (wf <= `TMO_MAX) begin
            n.tmo = wf;
          end else begin
            set[`ST_REJ] = 1'b1;
          end
        end
        `OFS_FUNC: begin
          if (func_ok(wf[26:0], reserved(s.ser_en, s.stb_en, s.wait_en))) begin
            n.func = wf[26:0];
          end else begin
            set[`ST_REJ] = 1'b1;
          end
        end
        `OFS_OUT:  n.dout = wf[8:0];
        `OFS_DIR:  n.ddir = wf[8:0];
        `OFS_MASK: n.mask = wf[3:0];
        default: ;
      endcase
    end
    // convert strobe
    case (s.sst)
      line_config_pkg::STB_IDLE: begin
        if (cmd_stb && s.stb_en) begin
          n.sst  = line_config_pkg::STB_PULSE;
          n.scnt = 5'h01;
        end else if (cmd_stb) begin
          set[`ST_REJ] = 1'b1;
        end
      end
      line_config_pkg::STB_PULSE: begin
        if (!n.stb_en) begin
          n.sst = line_config_pkg::STB_IDLE;
        end else if (s.scnt >= strobe_cycles(s.width)) begin
          n.sst         = line_config_pkg::STB_IDLE;
          set[`ST_STB]  = 1'b1;
        end else begin
          n.scnt = s.scnt + 5'h01;
        end
        if (cmd_stb) begin
          set[`ST_REJ] = 1'b1;
        end
      end
      default: n.sst = line_config_pkg::STB_IDLE;
    endcase
    // completion wait
    case (s.wst)
      line_config_pkg::WAIT_IDLE: begin
        if (cmd_wait && s.wait_en) begin
          n.wst  = line_config_pkg::WAIT_RUN;
          n.wcnt = 32'h0;
        end else if (cmd_wait) begin
          set[`ST_REJ] = 1'b1;
        end
      end
      line_config_pkg::WAIT_RUN: begin
        if (!s.wait_en) begin
          n.wst = line_config_pkg::WAIT_IDLE;
        end else if (!s.sync2[`LN_CMP]) begin
          n.wst         = line_config_pkg::WAIT_IDLE;
          set[`ST_DONE] = 1'b1;
        end else if (s.wcnt >= s.tmo) begin
          n.wst        = line_config_pkg::WAIT_IDLE;
          set[`ST_TMO] = 1'b1;
        end else begin
          n.wcnt = s.wcnt + 32'h1;
        end
        if (cmd_wait) begin
          set[`ST_REJ] = 1'b1;
        end
      end
      default: n.wst = line_config_pkg::WAIT_IDLE;
    endcase
    // a new event beats the read that clears it
    n.status = (s.status & ~clr) | set;
    n.irq    = |(n.status & n.mask);
    // general lines, then reserved lines override
    res = reserved(n.ser_en, n.stb_en, n.wait_en);
    for (int i = 0; i < 9; i++) begin
      n.pin_oe[i]  = 1'b0;
      n.pin_out[i] = 1'b0;
      case (fn_of(n.func, i))
        line_config_pkg::FN_TWO_WAY: begin
          n.pin_oe[i]  = n.ddir[i];
          n.pin_out[i] = n.dout[i];
        end
        line_config_pkg::FN_FIXED_HIGH: begin
          n.pin_oe[i]  = 1'b1;
          n.pin_out[i] = 1'b1;
        end
        line_config_pkg::FN_FIXED_LOW: begin
          n.pin_oe[i]  = 1'b1;
          n.pin_out[i] = 1'b0;
        end
        default: n.pin_oe[i] = 1'b0;
      endcase
      if (res[i]) begin
        n.pin_oe[i]  = 1'b0;
        n.pin_out[i] = 1'b0;
      end
    end
    if (n.ser_en) begin
      n.pin_oe[`LN_SCLK]  = 1'b1;
      n.pin_out[`LN_SCLK] = sclk;
      n.pin_oe[`LN_SEL]   = 1'b1;
      n.pin_out[`LN_SEL]  = ~n.ser_run;
      n.pin_oe[`LN_MOSI]  = 1'b1;
      n.pin_out[`LN_MOSI] = n.dout[`LN_MOSI];
    end
    if (n.stb_en) begin
      // strobe is active low, idles high
      n.pin_oe[`LN_STB]  = 1'b1;
      n.pin_out[`LN_STB] = n.sst != line_config_pkg::STB_PULSE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s      <= '0;
      s.half <= `HALF_RST;
      s.tmo  <= `TMO_RST;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = acc & ~s.resp;
  assign irq             = s.irq;
  assign line_out        = s.pin_out;
  assign line_oe         = s.pin_oe;

  // ****************************************************************
  // checks
  // ****************************************************************
  serial_lines_a: assert property (@(posedge clk_sys) disable iff (rst)
    s.ser_en |-> line_oe[`LN_SCLK] && line_oe[`LN_SEL] && line_oe[`LN_MOSI] && !line_oe[`LN_MISO])
    else $error("serial lines not held by serial engine");
  half_floor_a: assert property (@(posedge clk_sys) disable iff (rst)
    s.half >= `HALF_MIN)
    else $error("half period count below minimum");
  strobe_owner_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!s.stb_en |-> s.sst == line_config_pkg::STB_IDLE) and (s.stb_en |-> line_oe[`LN_STB]))
    else $error("strobe used or undriven outside its enable");
  strobe_width_a: assert property (@(posedge clk_sys) disable iff (rst)
    ($past(s.sst) == line_config_pkg::STB_PULSE && s.sst == line_config_pkg::STB_IDLE && s.stb_en)
    |-> $past(s.scnt) == strobe_cycles($past(s.width)) && line_out[`LN_STB])
    else $error("strobe ended at wrong width");
  wait_timeout_a: assert property (@(posedge clk_sys) disable iff (rst)
    (s.wst == line_config_pkg::WAIT_RUN && s.wait_en && s.sync2[`LN_CMP] && s.wcnt >= s.tmo)
    |=> s.status[`ST_TMO] && s.wst == line_config_pkg::WAIT_IDLE)
    else $error("timeout not reported");
  timeout_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    s.tmo <= `TMO_MAX)
    else $error("timeout count out of range");
  two_way_a: assert property (@(posedge clk_sys) disable iff (rst)
    fn_of(s.func, 6) == line_config_pkg::FN_TWO_WAY
    |-> line_oe[6] == s.ddir[6] && (!s.ddir[6] || line_out[6] == s.dout[6]))
    else $error("two-way line not following output registers");
  fixed_high_a: assert property (@(posedge clk_sys) disable iff (rst)
    fn_of(s.func, 7) == line_config_pkg::FN_FIXED_HIGH |-> line_oe[7] && line_out[7])
    else $error("fixed high line not driven high");
  fixed_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    fn_of(s.func, 8) == line_config_pkg::FN_FIXED_LOW |-> line_oe[8] && !line_out[8])
    else $error("fixed low line not driven low");
  input_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    (fn_of(s.func, 6) == line_config_pkg::FN_RECEIVE_ONLY || fn_of(s.func, 6) == line_config_pkg::FN_UNUSED)
    |-> !line_oe[6])
    else $error("input line driven");
  completion_input_a: assert property (@(posedge clk_sys) disable iff (rst)
    s.wait_en |-> !line_oe[`LN_CMP])
    else $error("completion line driven while reserved");
  wait_done_a: assert property (@(posedge clk_sys) disable iff (rst)
    (s.wst == line_config_pkg::WAIT_RUN && s.wait_en && !s.sync2[`LN_CMP])
    |=> (s.status[`ST_DONE] && !s.status[`ST_TMO]) || $past(s.status[`ST_TMO]))
    else $error("completion not reported");
endmodule // module_bus_line_config

// ==== plugin_module_model.sv ====
// far-side plug-in module model: completion answer and released lines
`timescale 1ns/1ps
`include "line_config_defines.svh"

module plugin_module_model (
  input  wire logic       clk_sys,
  input  wire logic [8:0] line_out,
  input  wire logic [8:0] line_oe,
  input  wire logic [7:0] resp_delay,
  output logic      [8:0] line_in
);
  logic [8:0] float_pat = 9'h0a5;
  logic       stb_q     = 1'b1;
  logic       cmp_n     = 1'b1;
  int         age       = 1000;

  // *****
  // completion answer after a strobe
  // *****
  // zero delay means the module never answers, for timeout runs
  always @(posedge clk_sys) begin
    float_pat <= ~float_pat;
    stb_q <= line_out[`LN_STB];
    if (stb_q && line_oe[`LN_STB] && !line_out[`LN_STB])
      age <= 0;
    else if (age < 1000)
      age <= age + 1;
    cmp_n <= !(resp_delay != 8'h00 && age >= resp_delay && age < resp_delay + 8);
  end

  // released lines other than completion toggle so a stale level never passes for a drive
  always_comb begin
    line_in = (line_oe & line_out) | (~line_oe & float_pat);
    line_in[`LN_CMP] = line_oe[`LN_CMP] ? line_out[`LN_CMP] : cmp_n;
  end
endmodule // plugin_module_model

// ==== testbench.sv ====
// self-checking bench of the backplane line block
`timescale 1ns/1ps
`include "line_config_defines.svh"

module testbench;
  logic        clk_sys        = 1'b0;
  logic        rst            = 1'b1;
  logic [3:0]  avs_address    = 4'h0;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [8:0]  line_in;
  logic [8:0]  line_out;
  logic [8:0]  line_oe;
  logic [7:0]  resp_delay     = 8'h00;
  logic [31:0] q;
  int          err_total      = 0;
  int          cmp_count      = 0;

  always #10 clk_sys = ~clk_sys;

  module_bus_line_config i_module_bus_line_config (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe));

  plugin_module_model i_plugin_module_model (.clk_sys(clk_sys), .line_out(line_out),
    .line_oe(line_oe), .resp_delay(resp_delay), .line_in(line_in));

  // *****
  // shared tasks
  // *****
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] ofs, input logic [31:0] d);
    avs_address   <= ofs[5:2];
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge clk_sys);
    // no cycle count assumed: only the watchdog ends a stuck request
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // one idle edge keeps back-to-back calls from reassigning in one step
    @(posedge clk_sys);
  endtask

  task automatic rdc(input string name, input logic [5:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0);
    chk(name, q, exp);
  endtask

  task automatic wait_lvl(input int b, input logic v);
    int n;
    n = 0;
    while (line_out[b] !== v && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk("line level", line_out[b], v);
  endtask

  task automatic run_len(input int b, input logic v, output int len);
    len = 0;
    while (line_out[b] === v && len < 2000) begin
      @(posedge clk_sys);
      len++;
    end
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    q = 32'h2;
    while (q[`LIVE_WAIT] !== 1'b0 && n < 100) begin
      bus(1'b0, `OFS_LIVE, 32'h0);
      n++;
    end
    chk("wait ended", q[`LIVE_WAIT], 32'h0);
  endtask

  // *****
  // scenarios
  // *****
  task automatic t_reset;
    rdc("ctrl", `OFS_CTRL, 32'h0);
    rdc("half", `OFS_HALF, {16'h0, `HALF_RST});
    rdc("timeout", `OFS_TMO, `TMO_RST);
    chk("oe at start", line_oe, 32'h0);
    chk("out at start", line_out, 32'h0);
    $display("t_reset done");
  endtask

  // line0 receive-only, 6 two-way, 7 fixed high, 8 fixed low, rest unused
  task automatic t_lines;
    bus(1'b1, `OFS_FUNC, 32'h0344_0004);
    chk("oe fixed", line_oe, 32'h180);
    chk("out fixed", line_out[8:7], 32'h1);
    bus(1'b1, `OFS_OUT, 32'h1ff);
    bus(1'b1, `OFS_DIR, 32'h1ff);
    chk("oe driven", line_oe, 32'h1c0);
    chk("out ones", line_out[8:6], 32'h3);
    // let the driven levels pass both synchroniser stages
    repeat (2) @(posedge clk_sys);
    bus(1'b0, `OFS_IN, 32'h0);
    chk("in sync", q[8:6], 32'h3);
    bus(1'b1, `OFS_OUT, 32'h0);
    chk("out zeros", line_out[8:6], 32'h2);
    bus(1'b1, `OFS_FUNC, 32'h0);
    chk("oe unused", line_oe, 32'h0);
    $display("t_lines done");
  endtask

  task automatic t_refuse;
    int ln[3] = '{1, 4, 5};
    bus(1'b0, `OFS_STAT, 32'h0);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `OFS_CTRL, 32'h1 << k);
      bus(1'b1, `OFS_FUNC, 32'h1 << (3 * ln[k]));
      rdc("reserved", `OFS_STAT, 32'h8);
      rdc("func kept", `OFS_FUNC, 32'h0);
    end
    bus(1'b1, `OFS_CTRL, 32'h0);
    bus(1'b1, `OFS_FUNC, 32'h5);
    rdc("bad code", `OFS_STAT, 32'h8);
    bus(1'b1, `OFS_HALF, 32'h1);
    rdc("half low", `OFS_STAT, 32'h8);
    rdc("half kept", `OFS_HALF, {16'h0, `HALF_RST});
    bus(1'b1, `OFS_HALF, 32'hffff);
    rdc("half top", `OFS_HALF, 32'hffff);
    bus(1'b1, `OFS_TMO, 32'hffff_ffff);
    rdc("tmo high", `OFS_STAT, 32'h8);
    bus(1'b1, `OFS_TMO, `TMO_MAX);
    rdc("tmo top", `OFS_TMO, `TMO_MAX);
    avs_byteenable <= 4'h1;
    bus(1'b1, `OFS_TMO, 32'h12);
    avs_byteenable <= 4'hf;
    rdc("tmo lane", `OFS_TMO, 32'hffff_ff12);
    bus(1'b1, `OFS_CTRL, 32'h32);
    rdc("width 3", `OFS_STAT, 32'h8);
    rdc("ctrl kept", `OFS_CTRL, 32'h2);
    $display("t_refuse done");
  endtask

  task automatic t_sclk;
    int lo;
    int hi;
    for (int h = 2; h < 4; h++) begin
      bus(1'b1, `OFS_HALF, h);
      bus(1'b1, `OFS_CTRL, 32'h9);
      chk("serial oe", line_oe[3:0], 32'h7);
      chk("select", line_out[`LN_SEL], 32'h0);
      wait_lvl(`LN_SCLK, 1'b1);
      wait_lvl(`LN_SCLK, 1'b0);
      run_len(`LN_SCLK, 1'b0, lo);
      run_len(`LN_SCLK, 1'b1, hi);
      chk("sclk low", lo, h);
      chk("sclk high", hi, h);
    end
    bus(1'b1, `OFS_CTRL, 32'h0);
    $display("t_sclk done");
  endtask

  task automatic t_strobe;
    int len;
    int wid[3] = '{`NS_TO_CYC(`STB_SHORT_NS), `NS_TO_CYC(`STB_MED_NS), `NS_TO_CYC(`STB_LONG_NS)};
    bus(1'b1, `OFS_CMD, 32'h1);
    rdc("stb off", `OFS_STAT, 32'h8);
    bus(1'b1, `OFS_MASK, 32'h1);
    for (int w = 0; w < 3; w++) begin
      bus(1'b1, `OFS_CTRL, 32'h2 | (w << 4));
      chk("stb idle", line_oe[`LN_STB] & line_out[`LN_STB], 32'h1);
      bus(1'b1, `OFS_CMD, 32'h1);
      wait_lvl(`LN_STB, 1'b0);
      run_len(`LN_STB, 1'b0, len);
      chk("stb width", len, wid[w]);
      repeat (2) @(posedge clk_sys);
      chk("irq set", irq, 32'h1);
      rdc("stb done", `OFS_STAT, 32'h1);
      chk("irq clear", irq, 32'h0);
    end
    bus(1'b1, `OFS_MASK, 32'h0);
    $display("t_strobe done");
  endtask

  task automatic t_wait;
    bus(1'b1, `OFS_CTRL, 32'h6);
    bus(1'b1, `OFS_TMO, 32'd40);
    resp_delay <= 8'h03;
    bus(1'b1, `OFS_CMD, 32'h3);
    wait_idle;
    rdc("wait done", `OFS_STAT, 32'h3);
    resp_delay <= 8'h00;
    bus(1'b1, `OFS_TMO, 32'd6);
    bus(1'b1, `OFS_CMD, 32'h2);
    wait_idle;
    rdc("timed out", `OFS_STAT, 32'h4);
    bus(1'b1, `OFS_TMO, 32'h0);
    bus(1'b1, `OFS_CMD, 32'h2);
    wait_idle;
    rdc("tmo zero", `OFS_STAT, 32'h4);
    $display("t_wait done");
  endtask

  // *****
  // run control
  // *****
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_lines;
    t_refuse;
    t_sclk;
    t_strobe;
    t_wait;
    complete_run;
  end

  // whole run needs a few hundred cycles; ten thousand is a hang
  initial begin
    #200000;
    err_total++;
    complete_run;
  end
endmodule // testbench
